// ==== core/gpd_port.sv ====
// Eight-pin bidirectional port with direction, output latch and shared pull-up, on APB.
`timescale 1ns/100ps
`include "gpd_params.svh"

// Function
// - Eight pins, each with own direction
// - Direction one puts driver in high impedance
// - Direction zero drives pin from latch
// - Latch register readable, returns latch value
// - Reset makes every pin an input
// - One shared bit enables all pull-ups
// - Pull-up off when pin is output
// - Reset clears shared pull-up control
module gpd_port (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire gpd_pkg::gpd_addr_t paddr,
  input wire gpd_pkg::gpd_word_t pwdata,
  output logic pready,
  output gpd_pkg::gpd_word_t prdata,
  output logic pslverr,
  // Port pins, split into level, drive value and active-low enable.
  input wire gpd_pkg::gpd_byte_t gpio_port_pins_in,
  output gpd_pkg::gpd_byte_t gpio_port_pins_out,
  output gpd_pkg::gpd_byte_t gpio_port_pins_oe_n,
  // Weak pull-up enable per pin.
  output gpd_pkg::gpd_byte_t gpio_pullup_on
);
  import gpd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and pin synchroniser.

  gpd_byte_t gpio_direction_bits_q;
  gpd_byte_t gpio_output_latch_q;
  gpd_byte_t pullup_host_direction_register_q;
  gpd_byte_t pin_meta_q;
  gpd_byte_t pin_sync_q;
  logic pready_q;
  logic pslverr_q;
  gpd_word_t prdata_q;
  gpd_byte_t pins_out_q;
  gpd_byte_t pins_oe_n_q;
  gpd_byte_t pullup_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  function automatic gpd_word_t gpd_zext(input gpd_byte_t b);
    gpd_zext = {24'h00_0000, b};
  endfunction : gpd_zext

  wire logic setup_phase = psel && !penable;
  wire logic hit_pins = (paddr == `GPD_OFF_PINS);
  wire logic hit_dir = (paddr == `GPD_OFF_DIR);
  wire logic hit_latch = (paddr == `GPD_OFF_LATCH);
  wire logic hit_host = (paddr == `GPD_OFF_PULLUP_HOST);
  wire logic hit_any = hit_pins || hit_dir || hit_latch || hit_host;
  // Answer one cycle after setup; the access phase always lasts one cycle.
  wire logic access_done = psel && penable && pready_q;
  wire logic wr_ok = access_done && pwrite && hit_any;
  // Both the data and latch offsets load the same latch.
  wire logic wr_latch = wr_ok && (hit_pins || hit_latch);
  wire logic wr_dir = wr_ok && hit_dir;
  wire logic wr_host = wr_ok && hit_host;
  wire gpd_word_t rd_word =
    hit_pins ? gpd_zext(pin_sync_q) :
    hit_latch ? gpd_zext(gpio_output_latch_q) :
    hit_dir ? gpd_zext(gpio_direction_bits_q) :
    hit_host ? gpd_zext(pullup_host_direction_register_q) :
    `GPD_ZERO_WORD;
  wire logic shared_pullup_enable = pullup_host_direction_register_q[`GPD_PULLUP_BIT];
  // A pin set as output never keeps its pull-up.
  wire gpd_byte_t pullup_d = {`GPD_WIDTH{shared_pullup_enable}} & gpio_direction_bits_q;
  wire gpd_byte_t pins_out_d = gpio_output_latch_q;
  // Enable is active low: direction one releases the pin.
  wire gpd_byte_t pins_oe_n_d = gpio_direction_bits_q;

  ////////////////////////////////////////////////////////////////////////////
  // Clocked state.

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      gpio_direction_bits_q <= `GPD_DIR_RESET;
      gpio_output_latch_q <= `GPD_LATCH_RESET;
      pullup_host_direction_register_q <= `GPD_PULLUP_HOST_RESET;
    end
    else
    begin
      if (wr_dir)
        gpio_direction_bits_q <= pwdata[`GPD_WIDTH-1:0];
      if (wr_latch)
        gpio_output_latch_q <= pwdata[`GPD_WIDTH-1:0];
      if (wr_host)
        pullup_host_direction_register_q <= pwdata[`GPD_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pin_meta_q <= `GPD_LATCH_RESET;
      pin_sync_q <= `GPD_LATCH_RESET;
    end
    else
    begin
      pin_meta_q <= gpio_port_pins_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `GPD_ZERO_WORD;
    end
    else
    begin
      pready_q <= setup_phase;
      pslverr_q <= setup_phase && !hit_any;
      prdata_q <= (setup_phase && !pwrite) ? rd_word : `GPD_ZERO_WORD;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pins_out_q <= `GPD_LATCH_RESET;
      pins_oe_n_q <= `GPD_DIR_RESET;
      pullup_q <= `GPD_LATCH_RESET;
    end
    else
    begin
      pins_out_q <= pins_out_d;
      pins_oe_n_q <= pins_oe_n_d;
      pullup_q <= pullup_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign gpio_port_pins_out = pins_out_q;
  assign gpio_port_pins_oe_n = pins_oe_n_q;
  assign gpio_pullup_on = pullup_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_dir_release;
    @(posedge clock) disable iff (!rstn)
    wr_dir ##1 1'b1 |-> ##1 gpio_port_pins_oe_n == $past(pwdata[`GPD_WIDTH-1:0], 2);
  endproperty
  a_dir_release: assert property (p_dir_release) else $error("enable does not follow direction");

  property p_drive_latch;
    @(posedge clock) disable iff (!rstn)
    wr_latch ##1 1'b1 |-> ##1 gpio_port_pins_out == $past(pwdata[`GPD_WIDTH-1:0], 2);
  endproperty
  a_drive_latch: assert property (p_drive_latch) else $error("pin drive does not follow latch");

  property p_latch_read;
    @(posedge clock) disable iff (!rstn)
    setup_phase && !pwrite && hit_latch |=> prdata == gpd_zext(gpio_output_latch_q);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read returned wrong value");

  property p_reset_input;
    @(posedge clock) !rstn |=> gpio_port_pins_oe_n == `GPD_DIR_RESET;
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pins not inputs after reset");

  property p_shared_pullup;
    @(posedge clock) disable iff (!rstn)
    (gpio_pullup_on != `GPD_LATCH_RESET) |-> $past(shared_pullup_enable);
  endproperty
  a_shared_pullup: assert property (p_shared_pullup) else $error("pull-up on without shared bit");

  property p_output_no_pullup;
    @(posedge clock) disable iff (!rstn)
    (gpio_pullup_on & ~gpio_port_pins_oe_n) == `GPD_LATCH_RESET;
  endproperty
  a_output_no_pullup: assert property (p_output_no_pullup) else $error("pull-up on driven pin");

  property p_reset_pullup;
    @(posedge clock) !rstn ##1 !rstn |=> gpio_pullup_on == `GPD_LATCH_RESET;
  endproperty
  a_reset_pullup: assert property (p_reset_pullup) else $error("pull-up on after reset");

  property p_pins_read;
    @(posedge clock) disable iff (!rstn)
    setup_phase && !pwrite && hit_pins |=> prdata == gpd_zext($past(pin_meta_q, 2));
  endproperty
  a_pins_read: assert property (p_pins_read) else $error("data read not pin level");

  property p_one_wait;
    @(posedge clock) disable iff (!rstn)
    setup_phase |=> pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready timing wrong");

  property p_oe_dir;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> gpio_port_pins_oe_n == $past(gpio_direction_bits_q);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("enable differs from direction");

  property p_pins_write;
    @(posedge clock) disable iff (!rstn)
    wr_ok && hit_pins |=> gpio_output_latch_q == $past(pwdata[`GPD_WIDTH-1:0]);
  endproperty
  a_pins_write: assert property (p_pins_write) else $error("latch missed write");

endmodule : gpd_port

// ==== core/gpd_params.svh ====
// Register offsets, reset values and widths for the bidirectional port.
`ifndef GPD_PARAMS_SVH
`define GPD_PARAMS_SVH

`define GPD_WIDTH 8
`define GPD_OFF_PINS 12'h000
`define GPD_OFF_DIR 12'h004
`define GPD_OFF_LATCH 12'h008
`define GPD_OFF_PULLUP_HOST 12'h00c
`define GPD_ADDR_W 12
`define GPD_DIR_RESET 8'hff
`define GPD_LATCH_RESET 8'h00
`define GPD_PULLUP_HOST_RESET 8'h00
`define GPD_PULLUP_BIT 7
`define GPD_ZERO_WORD 32'h0000_0000

`endif

// ==== core/gpd_pkg.sv ====
// Types shared by the bidirectional port.
`include "gpd_params.svh"

package gpd_pkg;

  typedef logic [`GPD_WIDTH-1:0] gpd_byte_t;
  typedef logic [`GPD_ADDR_W-1:0] gpd_addr_t;
  typedef logic [31:0] gpd_word_t;

endpackage : gpd_pkg

// ==== verification/gpd_pins_model.sv ====
// Board-side model of the eight port pins.
`timescale 1ns/100ps
`include "gpd_params.svh"
module gpd_pins_model (
  // Clock.
  input wire logic clock,
  // Device drive.
  input wire gpd_pkg::gpd_byte_t pins_out,
  input wire gpd_pkg::gpd_byte_t oe_n,
  input wire gpd_pkg::gpd_byte_t pullup_on,
  // Board drivers.
  input wire gpd_pkg::gpd_byte_t ext_en,
  input wire gpd_pkg::gpd_byte_t ext_val,
  // Resolved level.
  output gpd_pkg::gpd_byte_t level
);
  import gpd_pkg::*;
  gpd_byte_t last_q = 8'h00;
  // A floating pin toggles so that a stale value is never mistaken for a level.
  always_comb
  begin
    for (int i = 0; i < `GPD_WIDTH; i++)
    begin
      if (!oe_n[i])
        level[i] = pins_out[i];
      else if (ext_en[i])
        level[i] = ext_val[i];
      else if (pullup_on[i])
        level[i] = 1'b1;
      else
        level[i] = ~last_q[i];
    end
  end
  always_ff @(posedge clock) last_q <= level;
endmodule : gpd_pins_model

// ==== verification/bidirectional_gpio_port_d_test.sv ====
// Self-checking bench for the bidirectional port.
`timescale 1ns/100ps
`include "gpd_params.svh"
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module bidirectional_gpio_port_d_test;
  import gpd_pkg::*;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, err;
  gpd_addr_t paddr;
  gpd_word_t pwdata, prdata, rd;
  gpd_byte_t pins_in, pins_out, oe_n, pullup_on, ext_en, ext_val;
  int bad_count = 0;
  int check_count = 0;
  gpd_port dut_u (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .gpio_port_pins_in(pins_in), .gpio_port_pins_out(pins_out),
    .gpio_port_pins_oe_n(oe_n), .gpio_pullup_on(pullup_on));
  gpd_pins_model pins_u (.clock(clock), .pins_out(pins_out), .oe_n(oe_n),
    .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .level(pins_in));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input gpd_addr_t a, input logic w, input gpd_word_t d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_reset();
    `CHK("oe_n", 8'hff, oe_n)
    `CHK("pullup", 8'h00, pullup_on)
    apb(`GPD_OFF_DIR, 1'b0, 32'h0);
    `CHK("dir", 32'h0000_00ff, rd)
    apb(`GPD_OFF_PULLUP_HOST, 1'b0, 32'h0);
    `CHK("host", 32'h0000_0000, rd)
  endtask : t_reset
  // Pins 5:4 drive, the rest are driven by the board with a different pattern.
  task automatic t_drive();
    ext_en <= 8'hcf;
    ext_val <= 8'h0a;
    apb(`GPD_OFF_DIR, 1'b1, 32'h0000_00cf);
    apb(`GPD_OFF_PINS, 1'b1, 32'h0000_0030);
    repeat (3) @(posedge clock);
    `CHK("oe_n", 8'hcf, oe_n)
    `CHK("drive", 8'h30, pins_out)
    apb(`GPD_OFF_LATCH, 1'b0, 32'h0);
    `CHK("latch", 32'h0000_0030, rd)
    apb(`GPD_OFF_PINS, 1'b0, 32'h0);
    `CHK("pins", 32'h0000_003a, rd)
  endtask : t_drive
  task automatic t_pullup();
    ext_en <= 8'h00;
    apb(`GPD_OFF_PULLUP_HOST, 1'b1, 32'h0000_0080);
    repeat (3) @(posedge clock);
    `CHK("pullup", 8'hcf, pullup_on)
    apb(`GPD_OFF_PINS, 1'b0, 32'h0);
    `CHK("pins", 32'h0000_00ff, rd)
    apb(`GPD_OFF_PULLUP_HOST, 1'b1, 32'h0000_007f);
    repeat (3) @(posedge clock);
    `CHK("pullup", 8'h00, pullup_on)
    apb(12'h010, 1'b0, 32'h0);
    `CHK("unmapped", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
  endtask : t_pullup
  // A reset in mid-run must undo the outputs and the shared pull-up set just before it.
  task automatic t_rereset();
    apb(`GPD_OFF_PULLUP_HOST, 1'b1, 32'h0000_0080);
    repeat (3) @(posedge clock);
    `CHK("pullup", 8'hcf, pullup_on)
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    `CHK("oe_n", 8'hff, oe_n)
    `CHK("pullup", 8'h00, pullup_on)
    apb(`GPD_OFF_LATCH, 1'b0, 32'h0);
    `CHK("latch", 32'h0000_0000, rd)
    apb(`GPD_OFF_PULLUP_HOST, 1'b0, 32'h0);
    `CHK("host", 32'h0000_0000, rd)
  endtask : t_rereset
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_en = 8'h00;
    ext_val = 8'h00;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_drive();
    t_pullup();
    t_rereset();
    close_out();
  end
  // The run needs about 65 cycles, so 5000 only trips on a hang.
  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    close_out();
  end
endmodule : bidirectional_gpio_port_d_test
